// file: core/autoreset_timer.sv
// One condition's alarm latch and autoreset delay timer.
// Assumes fault is already synchronised and sec_tick is a one-cycle pulse per second.
`timescale 1ns/1ps
module autoreset_timer (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic sec_tick,
    input wire logic fault,
    input wire logic [fault_autoreset_pkg::DELAY_W-1:0] delay,
    input wire logic allow,
    input wire logic man_reset,
    output logic alarm,
    output logic trip,
    output logic auto_fire
);
    import fault_autoreset_pkg::*;

    logic alarm_r;
    logic [DELAY_W-1:0] cnt_r;
    logic expired;

    assign expired = alarm_r && !fault && (delay != DELAY_OFF) && (cnt_r == delay);
    assign auto_fire = expired && allow;
    assign trip = fault && !alarm_r;
    assign alarm = alarm_r;

    // Alarm latch; a present fault always wins over any clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_r <= 1'b0;
        end else if (fault) begin
            alarm_r <= 1'b1;
        end else if (auto_fire || man_reset) begin
            alarm_r <= 1'b0;
        end
    end

    // Seconds since the fault went away
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= DELAY_OFF;
        end else if (!alarm_r || fault) begin
            cnt_r <= DELAY_OFF;
        end else if (sec_tick && cnt_r != delay) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

endmodule // autoreset_timer

// file: core/fault_autoreset_delay_bank.sv
// Autoreset delay timers for sixteen drive conditions and trip-reaction selectors for nine of them,
// with an AXI4-Lite register slave.
// Assumes fault and ramp inputs come from outside the clock domain; one 20 MHz clock.
//
// Behaviour
// - Delay counts only after fault clears
// - Elapsed enabled delay clears alarm automatically
// - Delay 1..3600 s, zero means off
// - Reaction code 0 makes motor coast
// - Reaction code 1 makes controlled deceleration
// - Encoder fault has own autoreset delay
// - Motor-lost delay needs motor-lost supervision selected
// - Thermal overload has own reaction selector
// - Thermistor trip has own reaction selector
// - Link error has own reaction selector
// - Analog low alarm has own reaction
// - Load low alarm has own reaction
// - Load high alarm has own reaction
// - Coolant low level has own delay
// - Zero allowed trips disables all autoresets
// - Trip counter drops after ten idle minutes
// - Autoreset waits for remaining ramp time
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module fault_autoreset_delay_bank #(
    parameter int SEC_CYCLES = fault_autoreset_pkg::SEC_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    // Condition and ramp inputs
    input wire logic [fault_autoreset_pkg::NUM_COND-1:0] fault_in,
    input wire logic ramp_busy,
    // Reactions towards the motor control
    output logic [fault_autoreset_pkg::NUM_COND-1:0] alarm_out,
    output fault_autoreset_pkg::stop_t stop_out,
    // AXI4-Lite slave
    input wire logic [fault_autoreset_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fault_autoreset_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import fault_autoreset_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NUM_COND-1:0] fault_meta_r;
    logic [NUM_COND-1:0] fault_r;
    logic ramp_meta_r;
    logic ramp_r;
    logic [SEC_CNT_W-1:0] sec_cnt_r;
    logic sec_tick;

    ctrl_t ctrl_r;
    logic [NUM_COND-1:0] react_r;
    logic [DELAY_W-1:0] delay_r [NUM_COND];
    logic [DELAY_W-1:0] delay_eff [NUM_COND];
    logic man_reset_r;
    logic cnt_clear_r;

    logic [NUM_COND-1:0] alarm;
    logic [NUM_COND-1:0] trip;
    logic [NUM_COND-1:0] fire;
    logic [TRIPS_W-1:0] trip_cnt_r;
    logic [IDLE_W-1:0] idle_r;
    logic ar_ok;
    logic allow;
    stop_t stop_r;
    logic [NUM_COND-1:0] alarm_r;

    logic aw_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic w_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic do_write;
    logic [31:0] wr_ctrl;
    logic [31:0] wr_react;
    logic [31:0] wr_delay;
    logic [3:0] wr_idx;
    logic wr_is_delay;
    logic wr_hit;

    // ------------------------------------------------------------
    // Input synchronisers and seconds timebase
    // ------------------------------------------------------------
    // Two stages; only the second stage feeds logic
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_meta_r <= '0;
            fault_r <= '0;
            ramp_meta_r <= 1'b0;
            ramp_r <= 1'b0;
        end else begin
            fault_meta_r <= fault_in;
            fault_r <= fault_meta_r;
            ramp_meta_r <= ramp_busy;
            ramp_r <= ramp_meta_r;
        end
    end

    // One-cycle pulse per second; shorten SEC_CYCLES in simulation
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt_r <= '0;
        end else if (sec_cnt_r == SEC_CNT_W'(SEC_CYCLES - 1)) begin
            sec_cnt_r <= '0;
        end else begin
            sec_cnt_r <= sec_cnt_r + 1'b1;
        end
    end
    assign sec_tick = (sec_cnt_r == SEC_CNT_W'(SEC_CYCLES - 1));

    // ------------------------------------------------------------
    // Condition timers
    // ------------------------------------------------------------
    // zero trips disables
    assign ar_ok = (ctrl_r.max_trips != TRIPS_RST) && (trip_cnt_r <= ctrl_r.max_trips);
    assign allow = ar_ok && !ramp_r;

    for (genvar i = 0; i < NUM_COND; i++) begin : g_cond
        if (i == C_MOTOR_LOST) begin : g_lost
            assign delay_eff[i] = ctrl_r.lost_sel ? delay_r[i] : DELAY_OFF;
        end else begin : g_plain
            assign delay_eff[i] = delay_r[i];
        end
        autoreset_timer u_timer (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .sec_tick(sec_tick),
            .fault(fault_r[i]),
            .delay(delay_eff[i]),
            .allow(allow),
            .man_reset(man_reset_r),
            .alarm(alarm[i]),
            .trip(trip[i]),
            .auto_fire(fire[i])
        );
    end

    // ------------------------------------------------------------
    // Hidden trip counter
    // ------------------------------------------------------------
    // Counts trips, saturating; an idle stretch forgives one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            trip_cnt_r <= TRIPS_RST;
            idle_r <= '0;
        end else if (cnt_clear_r) begin
            trip_cnt_r <= TRIPS_RST;
            idle_r <= '0;
        end else if (|trip) begin
            if (trip_cnt_r != '1) begin
                trip_cnt_r <= trip_cnt_r + 1'b1;
            end
            idle_r <= '0;
        end else if (sec_tick) begin
            if (idle_r == IDLE_SECONDS) begin
                idle_r <= '0;
                if (trip_cnt_r != TRIPS_RST) begin
                    trip_cnt_r <= trip_cnt_r - 1'b1;
                end
            end else begin
                idle_r <= idle_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Stop reactions
    // ------------------------------------------------------------
    // Registered so the motor control sees glitch-free levels
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_r <= '0;
            alarm_r <= '0;
        end else begin
            alarm_r <= alarm;
            stop_r.coast <= |(alarm & ~(react_r & REACT_MASK));
            stop_r.decel <= |(alarm & react_r & REACT_MASK);
            stop_r.tripped <= |trip;
            stop_r.auto_reset <= |fire;
        end
    end
    assign alarm_out = alarm_r;
    assign stop_out = stop_r;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data are taken in either order; one write at a time
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Byte-lane merge of new data over a register's current image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    assign wr_is_delay = (awaddr_r >= A_DELAY_BASE) && (awaddr_r <= A_DELAY_LAST);
    assign wr_idx = awaddr_r[5:2];
    assign wr_hit = (awaddr_r == A_CTRL) || (awaddr_r == A_REACT) || (awaddr_r == A_STATUS)
        || (awaddr_r == A_FAULT) || (wr_is_delay && awaddr_r[1:0] == 2'h0);
    assign wr_ctrl = merge({23'h0, ctrl_r.lost_sel, 4'h0, ctrl_r.max_trips}, wdata_r, wstrb_r);
    assign wr_react = merge({16'h0000, react_r}, wdata_r, wstrb_r);
    assign wr_delay = merge({20'h00000, delay_r[wr_idx]}, wdata_r, wstrb_r);

    // Control register; the two action bits are self-clearing pulses
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r.max_trips <= TRIPS_RST;
            ctrl_r.lost_sel <= 1'b0;
            man_reset_r <= 1'b0;
            cnt_clear_r <= 1'b0;
        end else begin
            man_reset_r <= 1'b0;
            cnt_clear_r <= 1'b0;
            if (do_write && awaddr_r == A_CTRL) begin
                // Out-of-range trip limits are held at the top of the range
                if (wr_ctrl[F_MAX_TRIPS +: TRIPS_W] > TRIPS_MAX) begin
                    ctrl_r.max_trips <= TRIPS_MAX;
                end else begin
                    ctrl_r.max_trips <= wr_ctrl[F_MAX_TRIPS +: TRIPS_W];
                end
                ctrl_r.lost_sel <= wr_ctrl[F_LOST_SEL];
                man_reset_r <= wr_ctrl[F_MAN_RESET];
                cnt_clear_r <= wr_ctrl[F_CNT_CLEAR];
            end
        end
    end

    // Reaction selectors exist only for the conditions in REACT_MASK
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            react_r <= REACT_RST;
        end else if (do_write && awaddr_r == A_REACT) begin
            react_r <= wr_react[NUM_COND-1:0] & REACT_MASK;
        end
    end

    // Delay settings in whole seconds
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_COND; i++) begin
                delay_r[i] <= DELAY_OFF;
            end
        end else if (do_write && wr_is_delay && awaddr_r[1:0] == 2'h0) begin
            if (wr_delay[DELAY_W-1:0] > DELAY_MAX || wr_delay[31:DELAY_W] != '0) begin
                delay_r[wr_idx] <= DELAY_MAX;
            end else begin
                delay_r[wr_idx] <= wr_delay[DELAY_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
            if (s_axi_araddr == A_CTRL) begin
                rdata_r[F_MAX_TRIPS +: TRIPS_W] <= ctrl_r.max_trips;
                rdata_r[F_LOST_SEL] <= ctrl_r.lost_sel;
            end else if (s_axi_araddr == A_REACT) begin
                rdata_r[NUM_COND-1:0] <= react_r;
            end else if (s_axi_araddr == A_STATUS) begin
                rdata_r[F_ALARMS +: NUM_COND] <= alarm;
                rdata_r[F_TRIP_CNT +: TRIPS_W] <= trip_cnt_r;
                rdata_r[F_AR_OK] <= ar_ok;
                rdata_r[F_RAMP] <= ramp_r;
            end else if (s_axi_araddr == A_FAULT) begin
                rdata_r[NUM_COND-1:0] <= fault_r;
            end else if (s_axi_araddr >= A_DELAY_BASE && s_axi_araddr <= A_DELAY_LAST
                && s_axi_araddr[1:0] == 2'h0) begin
                rdata_r[DELAY_W-1:0] <= delay_r[s_axi_araddr[5:2]];
            end else begin
                // Unmapped reads answer zero with an error
                rresp_r <= RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule // fault_autoreset_delay_bank

// file: include/fault_autoreset_pkg.sv
// Constants, register map and field layouts of the fault autoreset delay bank.
// Assumes one 20 MHz clock and an AXI4-Lite master with 32-bit data.
package fault_autoreset_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_COND = 16;
    localparam int DELAY_W = 12;
    localparam int ADDR_W = 12;
    localparam int TRIPS_W = 4;
    localparam int IDLE_W = 10;
    localparam int SEC_CNT_W = 25;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_PERIOD_NS = 50;
    localparam longint SECOND_NS = 1000000000;
    localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
    // Trip counter forgives one trip after more than this many idle minutes
    localparam int IDLE_MINUTES = 10;
    localparam logic [IDLE_W-1:0] IDLE_SECONDS = IDLE_W'(IDLE_MINUTES * 60);

    // ------------------------------------------------------------
    // Setting ranges and reset values
    // ------------------------------------------------------------
    localparam logic [DELAY_W-1:0] DELAY_OFF = 12'h000;
    localparam logic [DELAY_W-1:0] DELAY_MAX = 12'he10;
    localparam logic [TRIPS_W-1:0] TRIPS_MAX = 4'ha;
    localparam logic [TRIPS_W-1:0] TRIPS_RST = 4'h0;
    localparam logic [NUM_COND-1:0] REACT_RST = 16'h0000;
    // Conditions that own a trip-reaction selector
    localparam logic [NUM_COND-1:0] REACT_MASK = 16'h7972;
    localparam logic REACT_COAST = 1'b0;
    localparam logic REACT_DECEL = 1'b1;

    // ------------------------------------------------------------
    // Condition indices
    // ------------------------------------------------------------
    localparam int C_POWER = 0;
    localparam int C_COOLANT = 1;
    localparam int C_MOTOR_LOST = 2;
    localparam int C_STALLED = 3;
    localparam int C_THERMAL = 4;
    localparam int C_RTD = 5;
    localparam int C_THERMISTOR = 6;
    localparam int C_OVERSPEED = 7;
    localparam int C_EXT_TEMP = 8;
    localparam int C_BRAKE = 9;
    localparam int C_ENCODER = 10;
    localparam int C_LINK_ERR = 11;
    localparam int C_ANALOG_LOW = 12;
    localparam int C_LOAD_LOW = 13;
    localparam int C_LOAD_HIGH = 14;
    localparam int C_PUMP = 15;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] A_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] A_REACT = 12'h004;
    localparam logic [ADDR_W-1:0] A_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] A_FAULT = 12'h00c;
    localparam logic [ADDR_W-1:0] A_DELAY_BASE = 12'h040;
    localparam logic [ADDR_W-1:0] A_DELAY_LAST = 12'h07c;

    // CTRL fields
    localparam int F_MAX_TRIPS = 0;
    localparam int F_LOST_SEL = 8;
    localparam int F_MAN_RESET = 16;
    localparam int F_CNT_CLEAR = 17;
    // STATUS fields
    localparam int F_ALARMS = 0;
    localparam int F_TRIP_CNT = 16;
    localparam int F_AR_OK = 24;
    localparam int F_RAMP = 25;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic lost_sel;
        logic [TRIPS_W-1:0] max_trips;
    } ctrl_t;

    typedef struct packed {
        logic coast;
        logic decel;
        logic tripped;
        logic auto_reset;
    } stop_t;

endpackage

// file: verif/fault_autoreset_assertions.sv
// Port-level checks of the fault autoreset delay bank.
// Assumes one clock domain; fault and ramp inputs pass two synchroniser flops inside.
`timescale 1ns/1ps
module fault_autoreset_checker #(
    parameter int SEC_CYCLES = 10
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [fault_autoreset_pkg::NUM_COND-1:0] fault_in,
    input wire logic ramp_busy,
    input wire logic [fault_autoreset_pkg::NUM_COND-1:0] alarm_out,
    input wire fault_autoreset_pkg::stop_t stop_out,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    import fault_autoreset_pkg::*;
    logic [5*NUM_COND-1:0] fh;
    logic [4:0] rh;
    logic [NUM_COND-1:0] held;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // ------------------------------------------------------------
    // Input history
    // ------------------------------------------------------------
    // Cleared by reset, so a fault from before a reset never counts as held
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fh <= '0;
            rh <= '0;
        end else begin
            fh <= {fh[4*NUM_COND-1:0], fault_in};
            rh <= {rh[3:0], ramp_busy};
        end
    end
    // Fault seen high three samples in a row, a margin over the sync depth
    assign held = fh[3*NUM_COND-1 -: NUM_COND] & fh[4*NUM_COND-1 -: NUM_COND] & fh[5*NUM_COND-1 -: NUM_COND];
    chk_alarm_on_fault:
    assert property ((held & ~alarm_out) == '0) else $error("alarm low while fault held");
    chk_stop_level:
    assert property ((stop_out.coast || stop_out.decel) == (alarm_out != '0)) else $error("stop level wrong");
    chk_trip_pulse:
    assert property (stop_out.tripped |=> (alarm_out & ~$past(alarm_out)) != '0) else $error("trip without alarm");
    chk_auto_clear:
    assert property (stop_out.auto_reset |=> (~alarm_out & $past(alarm_out)) != '0) else $error("autoreset no clear");
    chk_ramp_hold:
    assert property (&rh[4:1] |-> !stop_out.auto_reset) else $error("autoreset during ramp");
    chk_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    chk_one_bresp:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
endmodule // fault_autoreset_checker

bind fault_autoreset_delay_bank fault_autoreset_checker #(.SEC_CYCLES(SEC_CYCLES)) port_checker (
    .ref_clk, .reset_n, .fault_in, .ramp_busy, .alarm_out, .stop_out, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// file: verif/testbench.sv
// Self-checking bench for the fault autoreset delay bank.
// Assumes the checker binds itself; seconds shortened to SC clock cycles.
`timescale 1ns/1ps
module testbench;
    import fault_autoreset_pkg::*;
    localparam int SC = 10;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [NUM_COND-1:0] fault_in = '0;
    logic ramp_busy = 1'h0;
    logic [NUM_COND-1:0] alarm_out;
    stop_t stop_out;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_errors = 0, cmp_count = 0;

    fault_autoreset_delay_bank #(.SEC_CYCLES(SC)) fault_autoreset_delay_bank_inst (
        .ref_clk, .reset_n, .fault_in, .ramp_busy, .alarm_out, .stop_out, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );

    // Free-running 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data offered together; each released once taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (aw && s_axi_awready) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
        end while (s_axi_bvalid !== 1'h1);
        chk(34'(s_axi_bresp), 34'(RESP_OKAY));
        s_axi_bready <= 1'h0;
    endtask

    // Read one word, check response and data
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] re);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge ref_clk);
        s_axi_rready <= 1'h0;
        chk({s_axi_rresp, s_axi_rdata}, {re, e});
    endtask

    function automatic logic fires(input int i, input int d, input int mt, input int ls);
        return d != 0 && mt != 0 && (i != C_MOTOR_LOST || ls != 0);
    endfunction

    // Manual reset once the synchronised fault is gone
    task automatic mreset();
        cyc(3);
        wr(A_CTRL, 32'h00030000);
        cyc(6);
        chk(34'(alarm_out), 34'h0);
    endtask

    // One trip of condition i, then the autoreset window; trip counter cleared first
    task automatic arun(input int i, input int d, input int bn, input int mt, input int ls, input int rp);
        logic seen;
        int n;
        seen = 1'h0;
        wr(A_CTRL, 32'(mt) | 32'(ls) << 8 | 32'h00020000);
        wr(A_DELAY_BASE + ADDR_W'(4 * i), 32'(d));
        fault_in[i] <= 1'h1;
        cyc(6);
        chk(34'(alarm_out[i]), 34'h1);
        fault_in[i] <= 1'h0;
        ramp_busy <= rp[0];
        if (bn != 0) begin
            cyc(15);
            fault_in[i] <= 1'h1;
            cyc(6);
            fault_in[i] <= 1'h0;
        end
        cyc((d > 0 ? d - 1 : 3) * SC);
        chk(34'(alarm_out[i]), 34'h1);
        if (rp != 0) begin
            cyc(40);
            chk(34'(alarm_out[i]), 34'h1);
            ramp_busy <= 1'h0;
        end
        for (n = 0; n < 45 && alarm_out[i] !== 1'h0; n++) begin
            cyc(1);
            seen |= stop_out.auto_reset;
        end
        chk(34'({seen, ~alarm_out[i]}), 34'({2{fires(i, d, mt, ls)}}));
        if (alarm_out[i] !== 1'h0) mreset();
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] rv;
        void'($urandom(32'h5e4292ae));
        cyc(8);
        reset_n <= 1'h1;
        rd(A_CTRL, 32'h0, RESP_OKAY);
        rd(A_REACT, 32'(REACT_RST), RESP_OKAY);
        for (int i = 0; i < NUM_COND; i++) rd(A_DELAY_BASE + ADDR_W'(4 * i), 32'(DELAY_OFF), RESP_OKAY);
        rd(12'h100, 32'h0, RESP_SLVERR);
        wr(A_DELAY_BASE, 32'h00000fa0);
        rd(A_DELAY_BASE, 32'(DELAY_MAX), RESP_OKAY);
        wr(A_CTRL, 32'h0000001f);
        rd(A_CTRL, 32'(TRIPS_MAX), RESP_OKAY);
        wr(A_REACT, 32'hffffffff);
        rd(A_REACT, 32'(REACT_MASK), RESP_OKAY);
        // Random reaction codes, every condition tripped in turn
        rv = 16'($urandom);
        wr(A_REACT, 32'(rv));
        for (int i = 0; i < NUM_COND; i++) begin
            fault_in[i] <= 1'h1;
            cyc(6);
            chk(34'(alarm_out), 34'h1 << i);
            chk(34'({stop_out.coast, stop_out.decel}), 34'({~(rv[i] & REACT_MASK[i]), rv[i] & REACT_MASK[i]}));
            fault_in[i] <= 1'h0;
            mreset();
        end
        arun(C_COOLANT, 2, 0, 5, 0, 0);
        arun(C_ENCODER, 3, 1, 5, 0, 0);
        arun(C_POWER, 0, 0, 5, 0, 0);
        arun(C_MOTOR_LOST, 2, 0, 5, 0, 0);
        arun(C_MOTOR_LOST, 2, 0, 5, 1, 0);
        arun(C_PUMP, 1, 0, 0, 0, 0);
        arun(C_BRAKE, 1, 0, 3, 0, 1);
        wr(A_CTRL, 32'h0002000a);
        fault_in[0] <= 1'h1;
        cyc(6);
        rd(A_STATUS, 32'h01010001, RESP_OKAY);
        cyc(6100);
        rd(A_STATUS, 32'h01000001, RESP_OKAY);
        fault_in[0] <= 1'h0;
        mreset();
        repeat (4) arun($urandom_range(15), $urandom_range(3), 0, $urandom_range(10), 1, 0);
        print_verdict();
    end

    // Watchdog well past the expected run
    initial begin
        #2000000;
        n_errors++;
        print_verdict();
    end
endmodule // testbench
